// file: rtl/rx_sync_pkg.sv
// constants and carrier types for the receive status, alignment and serial port block
package rx_sync_pkg;

	// ==================================================
	// line structure
	localparam int BIT_W = 3;
	localparam int SLOT_W = 5;
	localparam int FRAME_W = 4;
	localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [SLOT_W-1:0] ALIGN_SLOT = 5'h00;
	localparam logic [SLOT_W-1:0] SIG_SLOT = 5'h10;
	localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h1F;
	localparam logic [FRAME_W-1:0] CAS_FIRST_FRAME = 4'h0;
	localparam logic [FRAME_W-1:0] CRC_HALF_FRAME = 4'h8;
	localparam logic [FRAME_W-1:0] CRC_SMF_END_A = 4'h7;
	localparam logic [FRAME_W-1:0] CRC_SMF_END_B = 4'hF;
	localparam logic [FRAME_W-1:0] CRC_WORD_FRAME = 4'hB;

	// ==================================================
	// alignment words and loss criteria
	localparam logic [6:0] FAS_WORD = 7'h1B;
	localparam logic [3:0] CAS_MF_WORD = 4'h0;
	localparam logic [5:0] CRC_MF_WORD = 6'h0B;
	localparam logic [3:0] CRC_POLY = 4'h3;
	localparam logic [1:0] FAS_LOSS_COUNT = 2'h3;
	localparam logic [1:0] CAS_LOSS_COUNT = 2'h2;
	localparam logic [5:0] CRC_TIMEOUT_MAX = 6'h20;
	localparam int CARRIER_ZEROS = 255;

	// ==================================================
	// serial port command byte and register map
	localparam int CMD_RW_BIT = 0;
	localparam int CMD_ADDR_LSB = 1;
	localparam int CMD_BURST_BIT = 7;
	localparam logic [3:0] PORT_BYTE_END = 4'h7;
	localparam logic [3:0] ADDR_MASK = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_RX_CTRL = 4'h5;
	localparam logic [3:0] ADDR_COMMON = 4'h6;
	localparam int CRC_EN_BIT = 2;
	localparam int STATUS_PIN_EN_BIT = 1;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] RX_CTRL_RESET = 8'h04;
	localparam logic [7:0] COMMON_RESET = 8'h00;

	typedef enum logic [1:0] {
		PORT_IDLE = 2'b00,
		PORT_CMD = 2'b01,
		PORT_DATA = 2'b10,
		PORT_DONE = 2'b11
	} port_state_t;

	// receive condition flags, also the status register layout (bit 7 first)
	typedef struct packed {
		logic syncLost;
		logic carrierLoss;
		logic mfAlarm;
		logic remoteAlarm;
		logic crcTimeout;
		logic crcSearch;
		logic casSearch;
		logic frameSearch;
	} rx_flags_t;

endpackage

// file: rtl/primary_rate_rx_sync_status.sv
// receive alignment, status outputs and host serial port of a 2.048 MHz primary-rate receiver
// ==================================================
// Contract
// - three search-active outputs high while frame, CAS or CRC4 search runs
// - CRC4 time-out output high when time-out counter reaches 32
// - time-out output cleared by CRC4 sync, CRC4 disable or reset
// - status outputs tri-stated when test low and status-pin enable zero
// - remote and distant multiframe alarm outputs follow alarm detection and clearing
// - alignment-frame output high throughout frames carrying the alignment signal
// - timeslot clock derived from receive clock, one cycle per timeslot
// - frame sync trailing edge marks start of each frame
// - CAS multiframe sync rises at multiframe start, high through frame 0
// - extracted signaling timeslot data output, changing on rising receive clock
// - signaling-slot marker high during timeslot 16 only
// - CRC4 multiframe sync high in frames 0 to 7, low 8 to 15
// - bipolar inputs sampled on falling edge; tied inputs mean NRZ, no violations
// - carrier loss shown by low-to-high transition of carrier loss output
// - violation output pulses for each detected bipolar violation
// - error output pulses on bad alignment word, CAS word or CRC4
// - loss-of-sync output high while any search runs
// - alarm conditions flagged on active-low open-drain interrupt
// - port samples on rising, drives on falling, serial out off unless reading
// - next eight port clocks carry data LSB first, in or out
module primary_rate_rx_sync_status
	import rx_sync_pkg::*;
#(
	parameter int CARRIER_LIMIT = CARRIER_ZEROS
) (
	// system clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// line side
	input wire logic rclk,
	input wire logic bipolar_in_positive,
	input wire logic bipolar_in_negative,
	// test and mode straps
	input wire logic testPin,
	input wire logic processor_mode_strap,
	// receive outputs
	output logic remote_alarm_out,
	output logic distant_multiframe_alarm_out,
	output logic rx_align_frame_marker,
	output logic rx_timeslot_clock,
	output logic rx_frame_start,
	output logic rx_cas_multiframe_start,
	output logic rx_signaling_out,
	output logic rx_signaling_slot_marker,
	output logic rx_crc_multiframe_start,
	output logic carrier_loss_out,
	output logic violation_pulse_out,
	output logic align_error_pulse_out,
	output logic sync_lost_out,
	// synchronizer status pins, enable low while driven
	output logic frame_align_search_flag,
	output logic cas_multiframe_search_flag,
	output logic crc_multiframe_search_flag,
	output logic crc_multiframe_timeout_flag,
	output logic statusOe_n,
	// host serial port
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic port_serial_in,
	output logic port_serial_out,
	output logic portOutOe_n,
	output logic intOut,
	output logic intOe_n
);

	function automatic logic atPos(input logic [SLOT_W-1:0] slot, input logic [BIT_W-1:0] bitPos,
			input logic [SLOT_W-1:0] wantSlot, input logic [BIT_W-1:0] wantBit);
		atPos = (slot == wantSlot) && (bitPos == wantBit);
	endfunction

	// ==================================================
	// link domain reset and control crossings
	logic [1:0] rxRst_reg;
	logic rxRst_n;
	logic [1:0] crcEnSync_reg, pinEnSync_reg, testSync_reg;
	logic crcEnCore, pinEnCore;

	always_ff @(posedge rclk or negedge nrst) begin
		if (!nrst) begin
			rxRst_reg <= 2'h0;
		end else begin
			rxRst_reg <= {rxRst_reg[0], 1'b1};
		end
	end
	assign rxRst_n = rxRst_reg[1];

	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			crcEnSync_reg <= 2'h0;
			pinEnSync_reg <= 2'h0;
			testSync_reg <= 2'h0;
		end else begin
			crcEnSync_reg <= {crcEnSync_reg[0], crcEnCore};
			pinEnSync_reg <= {pinEnSync_reg[0], pinEnCore};
			testSync_reg <= {testSync_reg[0], testPin};
		end
	end

	// ==================================================
	// line sampling
	logic posS_reg, negS_reg;

	always_ff @(negedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			posS_reg <= 1'b0;
			negS_reg <= 1'b0;
		end else begin
			posS_reg <= bipolar_in_positive;
			negS_reg <= bipolar_in_negative;
		end
	end

	// both rails high only when tied together, i.e. NRZ
	wire nrzBit = posS_reg & negS_reg;
	wire dataBit = posS_reg | negS_reg;
	wire markBit = posS_reg ^ negS_reg;
	logic lastMarkPos_reg;
	// two marks of the same polarity in a row
	wire bpvNow = markBit && (posS_reg == lastMarkPos_reg) && !nrzBit;

	// ==================================================
	// position counters and alignment state
	logic [BIT_W-1:0] bitCnt_reg;
	logic [SLOT_W-1:0] slotCnt_reg;
	logic [FRAME_W-1:0] casFrame_reg, crcFrame_reg;
	logic alignFrame_reg;
	logic [7:0] hist_reg;
	logic [5:0] siHist_reg;
	logic [1:0] fasErr_reg, casErr_reg;
	logic [5:0] crcTimer_reg;
	logic [3:0] crcCalc_reg, crcPrev_reg, cRecv_reg;
	logic crcPrevValid_reg;
	logic [7:0] zeroRun_reg;
	rx_flags_t flags_reg;

	wire [7:0] histNext = {hist_reg[6:0], dataBit};
	wire [5:0] siNext = {siHist_reg[4:0], histNext[7]};
	wire crcEn = crcEnSync_reg[1];
	wire endTs0 = atPos(slotCnt_reg, bitCnt_reg, ALIGN_SLOT, LAST_BIT);
	wire endTs16 = atPos(slotCnt_reg, bitCnt_reg, SIG_SLOT, LAST_BIT);
	wire endFrame = atPos(slotCnt_reg, bitCnt_reg, LAST_SLOT, LAST_BIT);
	wire cBitPos = alignFrame_reg && atPos(slotCnt_reg, bitCnt_reg, ALIGN_SLOT, 3'h0);
	wire smfEnd = endFrame && (crcFrame_reg == CRC_SMF_END_A || crcFrame_reg == CRC_SMF_END_B);
	wire fasFound = flags_reg.frameSearch && (histNext[6:0] == FAS_WORD);
	wire fasCheck = !flags_reg.frameSearch && endTs0 && alignFrame_reg;
	wire fasBad = fasCheck && (histNext[6:0] != FAS_WORD);
	wire casCheck = !flags_reg.frameSearch && endTs16 && (casFrame_reg == CAS_FIRST_FRAME);
	wire casBad = casCheck && !flags_reg.casSearch && (histNext[7:4] != CAS_MF_WORD);
	wire siSample = !flags_reg.frameSearch && endTs0 && !alignFrame_reg;
	wire crcFound = flags_reg.crcSearch && siSample && (siNext == CRC_MF_WORD);
	wire crcCheck = smfEnd && crcEn && !flags_reg.crcSearch && crcPrevValid_reg;
	wire crcBad = crcCheck && (cRecv_reg != crcPrev_reg);
	// c bits count as zero in the running remainder
	wire crcIn = cBitPos ? 1'b0 : dataBit;
	wire crcFb = crcCalc_reg[3] ^ crcIn;
	wire [3:0] crcStep = {crcCalc_reg[2:0], 1'b0} ^ (crcFb ? CRC_POLY : 4'h0);
	wire carrierGone = (zeroRun_reg == 8'(CARRIER_LIMIT));

	// counters are forced on a hit and otherwise free-run
	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			bitCnt_reg <= '0;
			slotCnt_reg <= '0;
			alignFrame_reg <= 1'b0;
		end else if (fasFound) begin
			bitCnt_reg <= '0;
			slotCnt_reg <= ALIGN_SLOT + 5'h01;
			alignFrame_reg <= 1'b1;
		end else begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			if (bitCnt_reg == LAST_BIT) begin
				slotCnt_reg <= slotCnt_reg + 5'h01;
			end
			if (endFrame) begin
				alignFrame_reg <= ~alignFrame_reg;
			end
		end
	end

	// multiframe counters: the word is found at the end of its slot
	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			casFrame_reg <= '0;
			crcFrame_reg <= '0;
		end else begin
			if (flags_reg.casSearch && endTs16 && !flags_reg.frameSearch && histNext[7:4] == CAS_MF_WORD) begin
				casFrame_reg <= CAS_FIRST_FRAME;
			end else if (endFrame) begin
				casFrame_reg <= casFrame_reg + 4'h1;
			end
			if (crcFound) begin
				crcFrame_reg <= CRC_WORD_FRAME;
			end else if (endFrame) begin
				crcFrame_reg <= crcFrame_reg + 4'h1;
			end
		end
	end

	// search flags and error counting
	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			flags_reg <= '{syncLost: 1'b1, frameSearch: 1'b1, casSearch: 1'b1, crcSearch: 1'b1, default: 1'b0};
			fasErr_reg <= '0;
			casErr_reg <= '0;
			crcTimer_reg <= '0;
		end else begin
			// frame search ends on the word, restarts after repeated errors
			if (fasFound) begin
				flags_reg.frameSearch <= 1'b0;
				fasErr_reg <= '0;
			end else if (fasBad && fasErr_reg == FAS_LOSS_COUNT - 2'h1) begin
				flags_reg.frameSearch <= 1'b1;
			end
			if (fasCheck) begin
				fasErr_reg <= fasBad ? fasErr_reg + 2'h1 : 2'h0;
			end
			if (flags_reg.frameSearch || (casBad && casErr_reg == CAS_LOSS_COUNT - 2'h1)) begin
				flags_reg.casSearch <= 1'b1;
				casErr_reg <= '0;
			end else if (flags_reg.casSearch && endTs16 && histNext[7:4] == CAS_MF_WORD) begin
				flags_reg.casSearch <= 1'b0;
			end else if (casCheck) begin
				casErr_reg <= casBad ? casErr_reg + 2'h1 : 2'h0;
			end
			// crc4 multiframe search, idle when crc4 is off
			if (!crcEn) begin
				flags_reg.crcSearch <= 1'b0;
			end else if (flags_reg.frameSearch) begin
				flags_reg.crcSearch <= 1'b1;
			end else if (crcFound) begin
				flags_reg.crcSearch <= 1'b0;
			end
			if (!crcEn || crcFound || !flags_reg.crcSearch) begin
				crcTimer_reg <= '0;
			// one count per multiframe period, saturating
			end else if (endFrame && crcFrame_reg == CRC_SMF_END_B && crcTimer_reg != CRC_TIMEOUT_MAX) begin
				crcTimer_reg <= crcTimer_reg + 6'h01;
			end
			flags_reg.crcTimeout <= (crcTimer_reg == CRC_TIMEOUT_MAX) && crcEn && !crcFound;
			// alarm bits read only while aligned
			if (siSample) begin
				flags_reg.remoteAlarm <= histNext[5];
			end else if (flags_reg.frameSearch) begin
				flags_reg.remoteAlarm <= 1'b0;
			end
			if (casCheck && !flags_reg.casSearch) begin
				flags_reg.mfAlarm <= histNext[2];
			end else if (flags_reg.casSearch) begin
				flags_reg.mfAlarm <= 1'b0;
			end
			// raised once the zero run reaches its limit
			flags_reg.carrierLoss <= carrierGone;
			// any search running
			// crc search is already forced off while crc4 is disabled; the sum is registered, so it lags the flags by one rclk
			flags_reg.syncLost <= flags_reg.frameSearch | flags_reg.casSearch | flags_reg.crcSearch;
		end
	end

	// history, crc4 remainder, zero run and polarity tracking
	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			hist_reg <= '0;
			siHist_reg <= '0;
			crcCalc_reg <= '0;
			crcPrev_reg <= '0;
			cRecv_reg <= '0;
			crcPrevValid_reg <= 1'b0;
			zeroRun_reg <= '0;
			lastMarkPos_reg <= 1'b0;
		end else begin
			hist_reg <= histNext;
			if (siSample) begin
				siHist_reg <= siNext;
			end
			if (cBitPos) begin
				cRecv_reg <= {cRecv_reg[2:0], dataBit};
			end
			// remainder of one sub-multiframe is checked against the next one's c bits
			if (smfEnd) begin
				crcPrev_reg <= crcStep;
				crcCalc_reg <= '0;
				crcPrevValid_reg <= !flags_reg.crcSearch && !crcFound;
			end else begin
				crcCalc_reg <= crcStep;
			end
			if (dataBit) begin
				zeroRun_reg <= '0;
			end else if (!carrierGone) begin
				zeroRun_reg <= zeroRun_reg + 8'h01;
			end
			if (markBit) begin
				lastMarkPos_reg <= posS_reg;
			end
		end
	end

	// ==================================================
	// registered line-side outputs, all delayed one rclk from the bit they describe
	logic statusOn;
	assign statusOn = testSync_reg[1] | pinEnSync_reg[1];

	always_ff @(posedge rclk or negedge rxRst_n) begin
		if (!rxRst_n) begin
			rx_timeslot_clock <= 1'b0;
			rx_frame_start <= 1'b0;
			rx_cas_multiframe_start <= 1'b0;
			rx_crc_multiframe_start <= 1'b0;
			rx_align_frame_marker <= 1'b0;
			rx_signaling_out <= 1'b0;
			rx_signaling_slot_marker <= 1'b0;
			violation_pulse_out <= 1'b0;
			align_error_pulse_out <= 1'b0;
			statusOe_n <= 1'b1;
		end else begin
			// high in the first half of each slot
			rx_timeslot_clock <= ~bitCnt_reg[BIT_W-1];
			// falls as the new frame begins
			rx_frame_start <= endFrame;
			rx_cas_multiframe_start <= (casFrame_reg == CAS_FIRST_FRAME) && !flags_reg.casSearch;
			// high for crc4 frames 0 to 7
			rx_crc_multiframe_start <= (crcFrame_reg < CRC_HALF_FRAME) && crcEn && !flags_reg.crcSearch;
			rx_align_frame_marker <= alignFrame_reg;
			rx_signaling_out <= (slotCnt_reg == SIG_SLOT) & dataBit;
			rx_signaling_slot_marker <= (slotCnt_reg == SIG_SLOT);
			violation_pulse_out <= bpvNow;
			// alignment, cas or crc4 word error
			align_error_pulse_out <= fasBad | casBad | crcBad;
			// status pins float unless test high or enabled
			statusOe_n <= ~statusOn;
		end
	end

	assign frame_align_search_flag = flags_reg.frameSearch;
	assign cas_multiframe_search_flag = flags_reg.casSearch;
	assign crc_multiframe_search_flag = flags_reg.crcSearch;
	assign crc_multiframe_timeout_flag = flags_reg.crcTimeout;
	assign remote_alarm_out = flags_reg.remoteAlarm;
	assign distant_multiframe_alarm_out = flags_reg.mfAlarm;
	assign carrier_loss_out = flags_reg.carrierLoss;
	assign sync_lost_out = flags_reg.syncLost;

	// ==================================================
	// core domain: pin synchronisers
	rx_flags_t flagsS1_reg, flagsS2_reg;
	logic [1:0] sclkS_reg, csS_reg, sdiS_reg, strapS_reg;
	logic sclkD_reg;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flagsS1_reg <= '0;
			flagsS2_reg <= '0;
			sclkS_reg <= '0;
			csS_reg <= 2'h3;
			sdiS_reg <= '0;
			strapS_reg <= '0;
			sclkD_reg <= 1'b0;
		end else begin
			flagsS1_reg <= flags_reg;
			flagsS2_reg <= flagsS1_reg;
			sclkS_reg <= {sclkS_reg[0], sclk};
			csS_reg <= {csS_reg[0], cs_n};
			sdiS_reg <= {sdiS_reg[0], port_serial_in};
			strapS_reg <= {strapS_reg[0], processor_mode_strap};
			sclkD_reg <= sclkS_reg[1];
		end
	end

	// hardware mode ignores the port and uses fixed settings
	wire procMode = strapS_reg[1];
	// a raised select ends any access
	wire portSel = procMode && !csS_reg[1];
	wire sclkRise = sclkS_reg[1] && !sclkD_reg;
	wire sclkFall = !sclkS_reg[1] && sclkD_reg;

	// ==================================================
	// serial port
	port_state_t portState_reg;
	logic [7:0] cmd_reg, wrShift_reg, rdShift_reg;
	logic [3:0] portBit_reg, addr_reg;
	logic isRead_reg, burst_reg, rdLoad_reg;
	logic [7:0] mask_reg, rxCtrl_reg, common_reg;

	wire [7:0] cmdNext = {sdiS_reg[1], cmd_reg[7:1]};
	wire [7:0] wrNext = {sdiS_reg[1], wrShift_reg[7:1]};
	wire byteDone = sclkRise && (portBit_reg == PORT_BYTE_END);
	logic [7:0] readData;

	always_comb begin
		unique case (addr_reg)
			ADDR_MASK: readData = mask_reg;
			ADDR_STATUS: readData = flagsS2_reg;
			ADDR_RX_CTRL: readData = rxCtrl_reg;
			ADDR_COMMON: readData = common_reg;
			default: readData = 8'h00;
		endcase
	end

	// command byte collected lsb first, then data bytes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			portState_reg <= PORT_IDLE;
			cmd_reg <= '0;
			portBit_reg <= '0;
			addr_reg <= '0;
			isRead_reg <= 1'b0;
			burst_reg <= 1'b0;
		end else if (!portSel) begin
			portState_reg <= PORT_IDLE;
			portBit_reg <= '0;
		end else begin
			if (sclkRise) begin
				portBit_reg <= portBit_reg + 4'h1;
			end
			unique case (portState_reg)
				PORT_IDLE: portState_reg <= PORT_CMD;
				PORT_CMD: begin
					if (sclkRise) begin
						cmd_reg <= cmdNext;
					end
					if (byteDone) begin
						portState_reg <= PORT_DATA;
						portBit_reg <= '0;
						isRead_reg <= cmdNext[CMD_RW_BIT];
						addr_reg <= cmdNext[CMD_ADDR_LSB +: 4];
						burst_reg <= cmdNext[CMD_BURST_BIT];
					end
				end
				PORT_DATA: begin
					// burst walks the whole map, single access stops after one byte
					if (byteDone) begin
						portBit_reg <= '0;
						addr_reg <= addr_reg + 4'h1;
						portState_reg <= burst_reg ? PORT_DATA : PORT_DONE;
					end
				end
				PORT_DONE: portState_reg <= PORT_DONE;
			endcase
		end
	end

	// input sampled on rising, registers written after the eighth data bit
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wrShift_reg <= '0;
			mask_reg <= MASK_RESET;
			rxCtrl_reg <= RX_CTRL_RESET;
			common_reg <= COMMON_RESET;
		end else if (portSel && portState_reg == PORT_DATA && !isRead_reg && sclkRise) begin
			wrShift_reg <= wrNext;
			if (byteDone) begin
				unique case (addr_reg)
					ADDR_MASK: mask_reg <= wrNext;
					ADDR_RX_CTRL: rxCtrl_reg <= wrNext;
					ADDR_COMMON: common_reg <= wrNext;
					default: ;
				endcase
			end
		end
	end

	// output changes on falling edges; first fall of a byte loads it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdShift_reg <= '0;
			rdLoad_reg <= 1'b1;
			port_serial_out <= 1'b0;
		end else if (portState_reg != PORT_DATA || !portSel) begin
			rdLoad_reg <= 1'b1;
		end else if (byteDone) begin
			rdLoad_reg <= 1'b1;
		end else if (sclkFall && isRead_reg) begin
			rdLoad_reg <= 1'b0;
			rdShift_reg <= rdLoad_reg ? {1'b0, readData[7:1]} : {1'b0, rdShift_reg[7:1]};
			port_serial_out <= rdLoad_reg ? readData[0] : rdShift_reg[0];
		end
	end

	// driven only while reading with select low
	assign portOutOe_n = !(portSel && portState_reg == PORT_DATA && isRead_reg);

	// settings used by the line side; hardware mode keeps crc4 on, status pins off
	assign crcEnCore = procMode ? rxCtrl_reg[CRC_EN_BIT] : 1'b1;
	assign pinEnCore = procMode ? common_reg[STATUS_PIN_EN_BIT] : 1'b0;

	// open drain: pulls low while an unmasked condition stands
	assign intOut = 1'b0;
	assign intOe_n = !(procMode && |(flagsS2_reg & mask_reg));

endmodule // primary_rate_rx_sync_status

// file: sim/primary_rate_rx_sync_status_sva.sv
// port checks for the receive status block
module rx_sync_status_sva (
	// clocks and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic rclk,
	// watched pins
	input wire logic testPin,
	input wire logic processor_mode_strap,
	input wire logic cs_n,
	input wire logic portOutOe_n,
	input wire logic statusOe_n,
	input wire logic sync_lost_out,
	input wire logic frame_align_search_flag,
	input wire logic cas_multiframe_search_flag,
	input wire logic crc_multiframe_search_flag,
	input wire logic crc_multiframe_timeout_flag,
	input wire logic rx_timeslot_clock,
	input wire logic rx_frame_start,
	input wire logic rx_align_frame_marker,
	input wire logic rx_signaling_slot_marker
);
	// ==================================================
	// sequences
	sequence slot_wave;
		rx_timeslot_clock[*4] ##1 !rx_timeslot_clock[*4] ##1 rx_timeslot_clock;
	endsequence
	sequence frame_gap;
		!rx_frame_start ##255 rx_frame_start;
	endsequence
	// ==================================================
	// line side
	a_sync_lost_sum: assert property (@(posedge rclk) disable iff (!nrst)
		sync_lost_out == $past(frame_align_search_flag | cas_multiframe_search_flag | crc_multiframe_search_flag))
		else $error("sync lost differs from searches");
	a_status_pin_drive: assert property (@(posedge rclk) disable iff (!nrst)
		testPin[*8] |-> !statusOe_n) else $error("status pins float with test high");
	a_slot_clock_wave: assert property (@(posedge rclk) disable iff (!nrst)
		$rose(rx_timeslot_clock) && !frame_align_search_flag |-> slot_wave) else $error("slot clock shape");
	a_frame_start_period: assert property (@(posedge rclk) disable iff (!nrst)
		$rose(rx_frame_start) && !frame_align_search_flag |-> ##1 frame_gap) else $error("frame period");
	a_align_frame_edge: assert property (@(posedge rclk) disable iff (!nrst)
		$changed(rx_align_frame_marker) && !$past(frame_align_search_flag) |-> $fell(rx_frame_start))
		else $error("align marker moved inside frame");
	a_sig_slot_len: assert property (@(posedge rclk) disable iff (!nrst)
		$rose(rx_signaling_slot_marker) && !frame_align_search_flag |->
		rx_signaling_slot_marker[*8] ##1 !rx_signaling_slot_marker)
		else $error("signaling slot length");
	a_timeout_clear: assert property (@(posedge rclk) disable iff (!nrst)
		$fell(crc_multiframe_search_flag) |=> !crc_multiframe_timeout_flag) else $error("timeout held");
	// ==================================================
	// host port
	a_port_out_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		cs_n[*5] |-> portOutOe_n) else $error("serial out driven while deselected");
	a_mode_port_off: assert property (@(posedge core_clk) disable iff (!nrst)
		!processor_mode_strap[*5] |-> portOutOe_n) else $error("serial out driven in hardware mode");
endmodule // rx_sync_status_sva

bind primary_rate_rx_sync_status rx_sync_status_sva i_rx_sync_status_sva (.*);

// file: sim/line_model.sv
// line receiver model: framed AMI stream and its receive clock
module line_model (
	// receive clock and rails
	output logic rclk,
	output logic bipolar_in_positive,
	output logic bipolar_in_negative,
	// fault injection
	input wire logic remAlarm,
	input wire logic badFas,
	input wire logic injectBpv,
	input wire logic silence
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] bitCnt = 8'h00;
	logic [3:0] frameCnt = 4'h0;
	logic lastPos = 1'b0;
	logic [7:0] octet;
	logic dataBit;
	logic markPos;
	initial begin
		bipolar_in_positive = 1'b0;
		bipolar_in_negative = 1'b0;
		rclk = 1'b0;
		#7;
		forever #16 rclk = ~rclk;
	end
	// payload chosen so no false alignment word and no long zero runs
	always_comb begin
		if (bitCnt[7:3] == 5'h00) octet = frameCnt[0] ? {2'b11, remAlarm, 5'h1F} : {1'b1, badFas ? 7'h1A : 7'h1B};
		else if (bitCnt[7:3] == 5'h10) octet = (frameCnt == 4'h0) ? 8'h0B : 8'hA5;
		else octet = 8'h55;
	end
	assign dataBit = octet[3'h7 - bitCnt[2:0]] & ~silence;
	assign markPos = injectBpv ~^ lastPos;
	// rails move on rising edges, settled for falling-edge sampling
	always @(posedge rclk) begin
		bitCnt <= bitCnt + 8'h01;
		if (bitCnt == 8'hFF) frameCnt <= frameCnt + 4'h1;
		bipolar_in_positive <= dataBit & markPos;
		bipolar_in_negative <= dataBit & ~markPos;
		if (dataBit) lastPos <= markPos;
	end
endmodule // line_model

// file: sim/primary_rate_rx_sync_status_tb_top.sv
// self-checking bench for the receive status block
module primary_rate_rx_sync_status_tb_top;
	import rx_sync_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, nrst, testPin, processor_mode_strap, sclk, cs_n, port_serial_in, hit;
	logic remAlarm, badFas, injectBpv, silence, rclk, bipolar_in_positive, bipolar_in_negative;
	logic remote_alarm_out, distant_multiframe_alarm_out, rx_align_frame_marker, rx_timeslot_clock;
	logic rx_frame_start, rx_cas_multiframe_start, rx_signaling_out, rx_signaling_slot_marker;
	logic rx_crc_multiframe_start, carrier_loss_out, violation_pulse_out, align_error_pulse_out;
	logic sync_lost_out, frame_align_search_flag, cas_multiframe_search_flag, crc_multiframe_search_flag;
	logic crc_multiframe_timeout_flag, statusOe_n, port_serial_out, portOutOe_n, intOut, intOe_n;
	logic [7:0] rd;
	int n_errors = 0;
	int compares = 0;
	line_model i_line_model (.*);
	primary_rate_rx_sync_status #(.CARRIER_LIMIT(8)) i_primary_rate_rx_sync_status (.*);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wait_for(ref logic sig, input logic v, input int limit, output logic found);
		for (int i = 0; i < limit && sig !== v; i++) @(posedge core_clk);
		found = (sig === v);
	endtask
	// ==================================================
	// serial port: command byte then data byte, LSB first, 48 ns phases
	task automatic port_xfer(input logic rw, input logic [3:0] addr, input logic [7:0] wd);
		logic [15:0] bits;
		// read/write, address, two zeros, no burst
		bits = {wd, 1'b0, 2'b00, addr, rw};
		// chip select low for the whole access
		cs_n <= 1'b0;
		ticks(12);
		for (int i = 0; i < 16; i++) begin
			sclk <= 1'b0;
			port_serial_in <= bits[i];
			ticks(11);
			@(negedge core_clk);
			if (i > 7) rd[i-8] = port_serial_out;
			if (!rw && i > 7) check({7'h00, portOutOe_n}, 8'h01);
			@(posedge core_clk);
			sclk <= 1'b1;
			ticks(12);
		end
		cs_n <= 1'b1;
		ticks(24);
	endtask
	// ==================================================
	// scenarios
	task automatic t_align();
		wait_for(cas_multiframe_search_flag, 1'b0, 40000, hit);
		check({6'h00, frame_align_search_flag, cas_multiframe_search_flag}, 8'h00);
		check({7'h00, sync_lost_out}, 8'h01);
		$display("alignment test done");
	endtask
	task automatic t_port();
		port_xfer(1'b1, ADDR_RX_CTRL, 8'h00);
		check(rd, RX_CTRL_RESET);
		port_xfer(1'b1, 4'h9, 8'h00);
		check(rd, 8'h00);
		port_xfer(1'b0, ADDR_MASK, 8'h80);
		ticks(16);
		check({7'h00, intOe_n}, 8'h00);
		port_xfer(1'b1, ADDR_STATUS, 8'h00);
		check(rd, 8'h84);
		port_xfer(1'b0, ADDR_COMMON, 8'h02);
		ticks(64);
		check({7'h00, statusOe_n}, 8'h00);
		port_xfer(1'b0, ADDR_RX_CTRL, 8'h00);
		ticks(64);
		check({4'h0, crc_multiframe_search_flag, crc_multiframe_timeout_flag, sync_lost_out, intOe_n}, 8'h01);
		port_xfer(1'b1, ADDR_STATUS, 8'h00);
		check(rd, 8'h00);
		$display("port test done");
	endtask
	task automatic t_line();
		fork
			begin
				badFas <= 1'b1;
				ticks(4096);
				badFas <= 1'b0;
			end
			wait_for(align_error_pulse_out, 1'b1, 6000, hit);
		join
		check({7'h00, hit}, 8'h01);
		injectBpv <= 1'b1;
		wait_for(violation_pulse_out, 1'b1, 64, hit);
		injectBpv <= 1'b0;
		check({7'h00, hit}, 8'h01);
		remAlarm <= 1'b1;
		wait_for(remote_alarm_out, 1'b1, 10000, hit);
		check({7'h00, hit}, 8'h01);
		remAlarm <= 1'b0;
		wait_for(remote_alarm_out, 1'b0, 10000, hit);
		check({7'h00, hit}, 8'h01);
		silence <= 1'b1;
		wait_for(carrier_loss_out, 1'b1, 400, hit);
		silence <= 1'b0;
		check({7'h00, hit}, 8'h01);
		wait_for(carrier_loss_out, 1'b0, 2000, hit);
		check({7'h00, hit}, 8'h01);
		$display("line test done");
	endtask
	task automatic t_mode();
		// reset around the change to hardware mode
		nrst <= 1'b0;
		processor_mode_strap <= 1'b0;
		ticks(80);
		nrst <= 1'b1;
		testPin <= 1'b1;
		ticks(80);
		port_xfer(1'b0, ADDR_MASK, 8'hFF);
		check({6'h00, intOe_n, statusOe_n}, 8'h02);
		$display("mode test done");
	endtask
	initial begin
		nrst = 1'b0;
		testPin = 1'b0;
		processor_mode_strap = 1'b1;
		sclk = 1'b1;
		cs_n = 1'b1;
		port_serial_in = 1'b0;
		{remAlarm, badFas, injectBpv, silence} = 4'h0;
		repeat (10) @(posedge rclk);
		@(posedge core_clk);
		nrst <= 1'b1;
		ticks(20);
		t_align();
		t_port();
		t_line();
		t_mode();
		report_and_stop();
	end
	initial begin
		#360000;
		n_errors++;
		report_and_stop();
	end
endmodule // primary_rate_rx_sync_status_tb_top
